// File: slave_output_banking_safety_path.sv
`timescale 1ns/100ps
// What this block does
// - Extended address, no four-output flag: three info bits drive outputs, four inputs returned.
// - Extended address plus four-output flag: I2 selects between two 2-bit output banks.
// - Banked: outputs and strobe update only on I2 low after previous I2 high.
// - I2 toggle detector resets to the I2 low state.
// - Banked: inputs sampled and returned on every data exchange call.
// - Banked, I2 high: I0/I1 go to two holding bits, pins unchanged.
// - Banked, I2 low: I0/I1 to outputs 2/3, held bits to outputs 0/1.
// - Extended address: I3 selects A-slave or B-slave at one address.
// - Safety flag steers 2:1 selector between regular and safety input paths.
// - Safety mode swaps D2 and D3; external generator swaps them too.
// - Inversion still applies in safety mode, mask bits tied to physical pins.
// - Safety mode sends D0 as D0 xor (D1 and D2 and D3).
// - Safety mode forces standard path bits to one through an OR.
// - Lockout set at reset, cleared by first parameter call; blocks data exchange.
// - Safety with sync I/O or any filter flag: lockout never clears.
// - All uses of inverted safety flag come from one inverter.
// - Synchronous data I/O is enabled when its flag is one; here the flag only keeps the lockout shut in safety mode.

module slave_output_banking_safety_path
(
  input wire logic clock,
  input wire logic rst,
  input wire logic callStrobe,
  input wire slave_data_pkg::call_kind_e callKind,
  input wire logic [3:0] callInfo,
  input wire logic extAddrMode,
  input wire logic bankedOutputEnable,
  input wire logic slaveIsB,
  input wire logic safetyMode,
  input wire logic syncDataIo,
  input wire logic [3:0] inputDebounceSelect,
  input wire logic [3:0] perInputInvertMask,
  input wire logic [3:0] dataInPins,
  output logic outPin0,
  output logic outPin1,
  output logic outPin2,
  output logic outPin3,
  output logic dataStrobe,
  output logic respValid,
  output logic [3:0] respData,
  output logic exchangeLocked
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed
  {
    slave_data_pkg::lock_e lock;
    logic i2Prev;
    logic [1:0] held;
    logic [3:0] outBits;
    logic strobe;
    logic respValid;
    logic [3:0] respData;
  } state_s;

  state_s s_q;
  state_s s_d;

  logic [3:0] inSync;
  logic [3:0] txData;
  logic bankedMode;
  logic abMatch;
  logic dexCall;
  logic dexAccepted;
  logic parCall;
  logic lockPinned;

  // ==========================================================
  // Input pins: synchroniser, then safety / standard path
  // ==========================================================
  input_sync
  #(
    .WIDTH(slave_data_pkg::DATA_WIDTH)
  )
  input_sync_i
  (
    .clock(clock),
    .rst(rst),
    .pinsAsync(dataInPins),
    .pinsSync(inSync)
  );

  safety_input_path safety_input_path_i
  (
    .physIn(inSync),
    .perInputInvertMask(perInputInvertMask),
    .safetyMode(safetyMode),
    .txData(txData)
  );

  // ==========================================================
  // Call decode
  // ==========================================================
  assign bankedMode = extAddrMode & bankedOutputEnable;

  // Outside extended addressing every call to this address is ours
  assign abMatch = ~extAddrMode | (callInfo[slave_data_pkg::INFO_AB_SEL] == slaveIsB);

  assign dexCall = callStrobe & (callKind == slave_data_pkg::CALL_DATA_EXCHANGE) & abMatch;

  assign dexAccepted = dexCall & (s_q.lock == slave_data_pkg::LOCK_OPEN);

  assign parCall = callStrobe & (callKind == slave_data_pkg::CALL_PARAMETER);

  // Delaying registers of sync I/O and filters would stretch the
  // safety reaction time, so that combination keeps the port shut
  assign lockPinned = safetyMode & (syncDataIo | (|inputDebounceSelect));

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    s_d = s_q;
    s_d.strobe = 1'b0;
    s_d.respValid = 1'b0;

    // Lockout release
    case (s_q.lock)
      slave_data_pkg::LOCK_CLOSED:
      begin
        if (parCall && !lockPinned)
        begin
          s_d.lock = slave_data_pkg::LOCK_OPEN;
        end
      end
      slave_data_pkg::LOCK_OPEN:
      begin
        s_d.lock = slave_data_pkg::LOCK_OPEN;
      end
      default:
      begin
        s_d.lock = slave_data_pkg::LOCK_CLOSED;
      end
    endcase

    if (dexAccepted)
    begin
      // Input side answers on every accepted call, bank or not
      s_d.respValid = 1'b1;
      s_d.respData = txData;

      if (bankedMode)
      begin
        if (callInfo[slave_data_pkg::INFO_BANK_SEL])
        begin
          s_d.held = callInfo[1:0];
          s_d.i2Prev = 1'b1;
        end
        else
        begin
          // Without a preceding I2 high call nothing is issued, so
          // a master that fails to alternate never moves the pins
          if (s_q.i2Prev)
          begin
            s_d.outBits = {callInfo[1:0], s_q.held};
            s_d.strobe = 1'b1;
          end
          s_d.i2Prev = 1'b0;
        end
      end
      else if (extAddrMode)
      begin
        // I3 carries the A/B select, so only three bits are data
        s_d.outBits[2:0] = callInfo[2:0];
        s_d.strobe = 1'b1;
      end
      else
      begin
        s_d.outBits = callInfo;
        s_d.strobe = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_q.lock <= slave_data_pkg::LOCK_RESET;
      s_q.i2Prev <= slave_data_pkg::I2_PREV_RESET;
      s_q.held <= slave_data_pkg::HELD_RESET;
      s_q.outBits <= slave_data_pkg::OUT_RESET;
      s_q.strobe <= 1'b0;
      s_q.respValid <= 1'b0;
      s_q.respData <= slave_data_pkg::RESP_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign outPin0 = s_q.outBits[0];
  assign outPin1 = s_q.outBits[1];
  assign outPin2 = s_q.outBits[2];
  assign outPin3 = s_q.outBits[3];
  assign dataStrobe = s_q.strobe;
  assign respValid = s_q.respValid;
  assign respData = s_q.respData;
  assign exchangeLocked = (s_q.lock != slave_data_pkg::LOCK_OPEN);

  // ==========================================================
  // Assertions
  // ==========================================================
  logic [3:0] logicalIn;
  logic [3:0] outNow;

  assign logicalIn = inSync ^ perInputInvertMask;
  assign outNow = {outPin3, outPin2, outPin1, outPin0};

  sequence bankLoadHigh;
    dexAccepted && bankedMode && callInfo[2];
  endsequence

  sequence bankFireLow;
    dexAccepted && bankedMode && !callInfo[2] && s_q.i2Prev;
  endsequence

  a_lock_blocks_exchange: assert property (
    @(posedge clock) disable iff (rst)
    dexCall && exchangeLocked |=> !respValid && !dataStrobe && $stable(outNow))
    else $error("Locked slave answered a data exchange call");

  a_lock_stays_pinned: assert property (
    @(posedge clock) disable iff (rst)
    exchangeLocked && lockPinned |=> exchangeLocked)
    else $error("Lockout cleared while safety forbids it");

  a_lock_param_opens: assert property (
    @(posedge clock) disable iff (rst)
    parCall && !lockPinned |=> !exchangeLocked)
    else $error("Parameter call did not clear lockout");

  a_bank_hold_pins: assert property (
    @(posedge clock) disable iff (rst)
    bankLoadHigh |=> $stable(outNow) && !dataStrobe && s_q.held == $past(callInfo[1:0]))
    else $error("I2 high call changed pins or missed hold");

  a_bank_fire_event: assert property (
    @(posedge clock) disable iff (rst)
    bankFireLow |=> dataStrobe && outNow == {$past(callInfo[1:0]), $past(s_q.held)})
    else $error("Bank transfer on I2 low call wrong");

  a_bank_no_fire: assert property (
    @(posedge clock) disable iff (rst)
    dexAccepted && bankedMode && !callInfo[2] && !s_q.i2Prev |=> !dataStrobe ##0 $stable(outNow))
    else $error("Output event without preceding I2 high call");

  a_bank_first_low: assert property (
    @(posedge clock)
    $fell(rst) ##0 (!dexAccepted || !callInfo[2]) [*2] |-> !s_q.i2Prev)
    else $error("Toggle detector did not start in I2 low state");

  a_resp_every_call: assert property (
    @(posedge clock) disable iff (rst)
    dexAccepted |=> respValid && respData == $past(txData))
    else $error("Accepted call not answered with sampled input");

  a_ab_select_miss: assert property (
    @(posedge clock) disable iff (rst)
    callStrobe && extAddrMode && callInfo[3] != slaveIsB |=> !respValid && !dataStrobe)
    else $error("Slave answered the other A/B half");

  a_direct_three_bits: assert property (
    @(posedge clock) disable iff (rst)
    dexAccepted && extAddrMode && !bankedOutputEnable
      |=> dataStrobe && outNow[2:0] == $past(callInfo[2:0]) && $stable(outNow[3]))
    else $error("Extended mode direct output wrong");

  a_direct_four_bits: assert property (
    @(posedge clock) disable iff (rst)
    dexAccepted && !extAddrMode |=> dataStrobe && outNow == $past(callInfo))
    else $error("Standard mode direct output wrong");

  a_safety_recode: assert property (
    @(posedge clock) disable iff (rst)
    safetyMode |-> txData == {logicalIn[2], logicalIn[3], logicalIn[1],
      logicalIn[0] ^ (logicalIn[1] & logicalIn[2] & logicalIn[3])})
    else $error("Safety path swap or D0 recode wrong");

  a_standard_path: assert property (
    @(posedge clock) disable iff (rst)
    !safetyMode |-> txData == logicalIn)
    else $error("Regular path altered outside safety mode");

  a_strobe_one_cycle: assert property (
    @(posedge clock) disable iff (rst)
    dataStrobe |=> !dataStrobe || $past(dexAccepted))
    else $error("Strobe held without a new call");

  sequence bankArmGapFire;
    bankLoadHigh ##1 !dexAccepted ##1 bankFireLow;
  endsequence

  a_bank_pair_order: assert property (
    @(posedge clock) disable iff (rst)
    bankArmGapFire |=> outNow[1:0] == $past(callInfo[1:0], 3) && outNow[3:2] == $past(callInfo[1:0]))
    else $error("Banks not assembled from I2 high then I2 low call");

  a_lock_after_reset: assert property (
    @(posedge clock)
    $fell(rst) |-> exchangeLocked && !respValid && !dataStrobe)
    else $error("Lockout not set after reset");

  a_lock_never_recloses: assert property (
    @(posedge clock) disable iff (rst)
    !exchangeLocked |=> !exchangeLocked)
    else $error("Lockout closed again without reset");

  a_strobe_needs_call: assert property (
    @(posedge clock) disable iff (rst)
    dataStrobe |-> $past(dexAccepted))
    else $error("Strobe without accepted call");

  a_resp_needs_call: assert property (
    @(posedge clock) disable iff (rst)
    respValid |-> $past(dexAccepted))
    else $error("Response without accepted call");

  a_resp_holds_idle: assert property (
    @(posedge clock) disable iff (rst)
    !dexAccepted |=> $stable(respData))
    else $error("Response data changed without a call");

  a_pins_hold_idle: assert property (
    @(posedge clock) disable iff (rst)
    !dexAccepted |=> $stable(outNow))
    else $error("Output pins changed without a call");

  a_std_forced_ones: assert property (
    @(posedge clock) disable iff (rst)
    safetyMode |-> safety_input_path_i.stdPath == 4'hF)
    else $error("Standard path not forced to ones in safety mode");

  a_mask_on_pins: assert property (
    @(posedge clock) disable iff (rst)
    safetyMode |-> txData[2] == (inSync[3] ^ perInputInvertMask[3])
      && txData[3] == (inSync[2] ^ perInputInvertMask[2]))
    else $error("Invert mask not tied to physical pins");

endmodule

// File: slave_data_pkg.sv
package slave_data_pkg;

  // ==========================================================
  // Kinds of master call delivered by the receiver
  // ==========================================================
  typedef enum logic [1:0]
  {
    CALL_DATA_EXCHANGE = 2'h0,
    CALL_PARAMETER = 2'h1,
    CALL_OTHER = 2'h2
  } call_kind_e;

  // ==========================================================
  // Data exchange lockout states
  // ==========================================================
  typedef enum logic [1:0]
  {
    LOCK_CLOSED = 2'h0,
    LOCK_OPEN = 2'h1
  } lock_e;

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int DATA_WIDTH = 4;
  localparam int INFO_BANK_SEL = 2;
  localparam int INFO_AB_SEL = 3;
  localparam logic [3:0] OUT_RESET = 4'h0;
  localparam logic [1:0] HELD_RESET = 2'h0;
  localparam logic [3:0] RESP_RESET = 4'h0;
  localparam logic I2_PREV_RESET = 1'h0;
  localparam lock_e LOCK_RESET = LOCK_CLOSED;

endpackage

// File: input_sync.sv
`timescale 1ns/100ps

module input_sync
#(
  parameter int WIDTH = 4
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinsAsync,
  output logic [WIDTH-1:0] pinsSync
);

  typedef struct packed
  {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // ==========================================================
  // Two flops; stage1 is read only by stage2
  // ==========================================================
  always_comb
  begin
    s_d = s_q;
    s_d.stage1 = pinsAsync;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign pinsSync = s_q.stage2;

endmodule

// File: safety_input_path.sv
`timescale 1ns/100ps

module safety_input_path
(
  input wire logic [3:0] physIn,
  input wire logic [3:0] perInputInvertMask,
  input wire logic safetyMode,
  output logic [3:0] txData
);

  logic safetyModeN;
  logic [3:0] logicalIn;
  logic [3:0] safePath;
  logic [3:0] stdPath;

  // ==========================================================
  // Inversion on physical pins, ahead of any swap
  // ==========================================================
  // Mask bits follow pins, so mask bit 3 ends up on logical D2
  assign logicalIn = physIn ^ perInputInvertMask;

  // ==========================================================
  // Safety path: swap D2/D3, then recode D0
  // ==========================================================
  always_comb
  begin
    safePath[1:0] = logicalIn[1:0];
    safePath[2] = logicalIn[3];
    safePath[3] = logicalIn[2];
    safePath[0] = logicalIn[0] ^ (logicalIn[1] & logicalIn[3] & logicalIn[2]);
  end

  // The one and only inverter of the safety flag
  assign safetyModeN = ~safetyMode;

  // Forced to ones so a single stuck selector yields a bad code
  assign stdPath = logicalIn | {4{safetyMode}};

  // 2:1 selector ahead of the send multiplexer
  assign txData = (safePath & {4{safetyMode}}) | (stdPath & {4{safetyModeN}});

endmodule

// File: network_master_model.sv
`timescale 1ns/100ps

// ==========================================================
// Master side of the call port
// ==========================================================
module network_master_model
(
  input wire logic clock,
  output logic callStrobe,
  output slave_data_pkg::call_kind_e callKind,
  output logic [3:0] callInfo
);
  initial
  begin
    callStrobe = 1'b0;
    callKind = slave_data_pkg::CALL_OTHER;
    callInfo = 4'h0;
  end

  // One call per strobe; the bench picks I2 so banks alternate except where a test breaks it
  task automatic issueCall(input slave_data_pkg::call_kind_e kind, input logic [3:0] info);
    @(negedge clock);
    callStrobe = 1'b1;
    callKind = kind;
    callInfo = info;
    @(negedge clock);
    callStrobe = 1'b0;
    callKind = slave_data_pkg::CALL_OTHER;
    // Released bits show no stale value
    callInfo = ~info;
  endtask
endmodule

// File: tb_slave_output_banking_safety_path.sv
`timescale 1ns/100ps
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin errTotal++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_slave_output_banking_safety_path;
  // ==========================================================
  // Signals and instances
  // ==========================================================
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic callStrobe;
  slave_data_pkg::call_kind_e callKind;
  logic [3:0] callInfo;
  logic extAddrMode = 1'b0;
  logic bankedOutputEnable = 1'b0;
  logic slaveIsB = 1'b0;
  logic safetyMode = 1'b0;
  logic syncDataIo = 1'b0;
  logic [3:0] inputDebounceSelect = 4'h0;
  logic [3:0] perInputInvertMask = 4'h0;
  logic [3:0] dataInPins = 4'h0;
  logic outPin0, outPin1, outPin2, outPin3;
  logic dataStrobe, respValid, exchangeLocked;
  logic [3:0] respData;
  logic [3:0] outs;
  logic [3:0] phys;
  int errTotal = 0;
  int cmpCount = 0;
  localparam slave_data_pkg::call_kind_e DX = slave_data_pkg::CALL_DATA_EXCHANGE;
  localparam slave_data_pkg::call_kind_e PAR = slave_data_pkg::CALL_PARAMETER;

  assign outs = {outPin3, outPin2, outPin1, outPin0};
  always #50 clock = ~clock;

  network_master_model network_master_model_i
  (
    .clock(clock),
    .callStrobe(callStrobe),
    .callKind(callKind),
    .callInfo(callInfo)
  );

  slave_output_banking_safety_path slave_output_banking_safety_path_i
  (
    .clock(clock),
    .rst(rst),
    .callStrobe(callStrobe),
    .callKind(callKind),
    .callInfo(callInfo),
    .extAddrMode(extAddrMode),
    .bankedOutputEnable(bankedOutputEnable),
    .slaveIsB(slaveIsB),
    .safetyMode(safetyMode),
    .syncDataIo(syncDataIo),
    .inputDebounceSelect(inputDebounceSelect),
    .perInputInvertMask(perInputInvertMask),
    .dataInPins(dataInPins),
    .outPin0(outPin0),
    .outPin1(outPin1),
    .outPin2(outPin2),
    .outPin3(outPin3),
    .dataStrobe(dataStrobe),
    .respValid(respValid),
    .respData(respData),
    .exchangeLocked(exchangeLocked)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [3:0] expTx(input logic [3:0] p, input logic [3:0] m, input logic safe);
    logic [3:0] l;
    logic [3:0] s;
    l = p ^ m;
    s = {l[2], l[3], l[1], l[0]};
    s[0] = s[0] ^ (s[1] & s[2] & s[3]);
    return safe ? s : l;
  endfunction

  // Code generator: all-ones never intended, so 1111 stands for 1110; D2/D3 swapped
  function automatic logic [3:0] present(input logic [3:0] v, input logic [3:0] m);
    logic [3:0] t;
    t = (v == 4'hE) ? 4'hF : v;
    return {t[2], t[3], t[1], t[0]} ^ m;
  endfunction

  task automatic setPins(input logic [3:0] v);
    @(negedge clock);
    dataInPins = v;
    // Two sync flops plus margin
    repeat (3) @(negedge clock);
  endtask

  task automatic callChk(input slave_data_pkg::call_kind_e k, input logic [3:0] info,
                         input logic expValid, input logic expStrobe, input logic [3:0] expPins);
    // Response and strobe stand one cycle: look at the negedge that ends the call
    network_master_model_i.issueCall(k, info);
    `CHK(respValid, expValid)
    `CHK(dataStrobe, expStrobe)
    `CHK(outs, expPins)
  endtask

  task automatic doReset;
    @(negedge clock);
    rst = 1'b1;
    repeat (3) @(negedge clock);
    rst = 1'b0;
  endtask

  task automatic printVerdict;
    if (errTotal == 0 && cmpCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    errTotal++;
    printVerdict();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial
  begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    `CHK(exchangeLocked, 1'b1)
    `CHK(outs, 4'h0)
    perInputInvertMask = 4'h3;
    setPins(4'h9);
    callChk(DX, 4'h5, 1'b0, 1'b0, 4'h0);
    network_master_model_i.issueCall(PAR, 4'h0);
    @(negedge clock);
    `CHK(exchangeLocked, 1'b0)
    callChk(DX, 4'h5, 1'b1, 1'b1, 4'h5);
    `CHK(respData, expTx(4'h9, 4'h3, 1'b0))
    callChk(DX, 4'hA, 1'b1, 1'b1, 4'hA);
    extAddrMode = 1'b1;
    callChk(DX, 4'h5, 1'b1, 1'b1, 4'hD);
    callChk(DX, 4'h8, 1'b0, 1'b0, 4'hD);
    bankedOutputEnable = 1'b1;
    slaveIsB = 1'b1;
    callChk(DX, 4'h8, 1'b1, 1'b0, 4'hD);
    setPins(4'h6);
    callChk(DX, 4'hD, 1'b1, 1'b0, 4'hD);
    `CHK(respData, expTx(4'h6, 4'h3, 1'b0))
    callChk(DX, 4'hA, 1'b1, 1'b1, 4'h9);
    callChk(DX, 4'h9, 1'b1, 1'b0, 4'h9);
    callChk(DX, 4'hF, 1'b1, 1'b0, 4'h9);
    callChk(DX, 4'h8, 1'b1, 1'b1, 4'h3);
    extAddrMode = 1'b0;
    bankedOutputEnable = 1'b0;
    safetyMode = 1'b1;
    perInputInvertMask = 4'h4;
    for (int v = 0; v < 16; v++)
    begin
      phys = present(v[3:0], 4'h4);
      setPins(phys);
      callChk(DX, 4'h0, 1'b1, 1'b1, 4'h0);
      `CHK(respData, expTx(phys, 4'h4, 1'b1))
      if (v == 14)
        `CHK(respData, 4'hE)
    end
    for (int c = 0; c < 2; c++)
    begin
      syncDataIo = (c == 0);
      inputDebounceSelect = (c == 0) ? 4'h0 : 4'h2;
      doReset();
      network_master_model_i.issueCall(PAR, 4'h0);
      @(negedge clock);
      `CHK(exchangeLocked, 1'b1)
      callChk(DX, 4'h0, 1'b0, 1'b0, 4'h0);
    end
    safetyMode = 1'b0;
    syncDataIo = 1'b1;
    doReset();
    network_master_model_i.issueCall(PAR, 4'h0);
    @(negedge clock);
    `CHK(exchangeLocked, 1'b0)
    printVerdict();
  end
endmodule
